// [core/offset_adder.sv]
// 16-bit base plus 8-bit offset, zero or sign extended
// assumes purely combinational use; result wraps inside 64 Kbyte
`timescale 1ns/1ps
module offset_adder (
  input  wire logic [15:0] base_i,
  input  wire logic [7:0]  off_i,
  input  wire logic        sext_i,
  output logic      [15:0] sum_o
);

  // ------------------------------------------------------------------
  // sum
  // ------------------------------------------------------------------
  logic [7:0] ext_hi;

  always_comb begin
    ext_hi = {8{sext_i & off_i[7]}};
    // carry out dropped on purpose: addresses wrap in 16 bits
    sum_o  = base_i + {ext_hi, off_i};
  end

endmodule // offset_adder

// [core/operand_address_generator.sv]
// operand fetch and effective address forming for an 8-bit core
// assumes memory answers a held request with ack and data together
//
// What this block does
// [RULE1] immediate: opcode plus one operand value byte
// [RULE2] short direct: one address byte, 00-FF
// [RULE3] long direct: two address bytes, full space
// [RULE4] indexed: unsigned sum of X/Y and offset
// [RULE5] no-offset indexed: no byte, index is address
// [RULE6] short indexed: byte offset plus index, 00-1FE
// [RULE7] long indexed: word offset plus index
// [RULE8] indirect: byte after opcode addresses the pointer
// [RULE9] short indirect: byte pointer, 00-FF reach
// [RULE10] long indirect forms: byte address, word pointer
// [RULE11] indirect indexed: index plus fetched pointer
// [RULE12] short indirect indexed: byte pointer, 00-1FE
// [RULE13] relative: PC plus sign-extended byte offset
// [RULE14] direct relative: offset byte follows opcode
// [RULE15] indirect relative: offset read from memory
// [RULE16] short-only instructions refuse long modes
// [RULE17] interrupt vector fetch: finish plus ten cycles
// [RULE18] word bytes: earlier byte is high half
// [RULE19] long indexed sums truncated to 16 bits
`timescale 1ns/1ps
module operand_address_generator (
  input  wire logic                   clk_i,
  input  wire logic                   arst_n_i,
  input  wire logic                   ce_i,
  input  wire logic                   start_i,
  input  wire opgen_pkg::addr_mode_e  mode_i,
  input  wire logic                   short_only_i,
  input  wire logic                   use_y_i,
  input  wire logic [7:0]             idx_x_i,
  input  wire logic [7:0]             idx_y_i,
  input  wire logic [15:0]            pc_i,
  input  wire logic                   mem_ack_i,
  input  wire logic [7:0]             mem_rdata_i,
  input  wire logic                   irq_i,
  output logic                        mem_req_o,
  output logic      [15:0]            mem_addr_o,
  output logic                        busy_o,
  output logic                        done_o,
  output logic                        illegal_o,
  output logic      [15:0]            ea_o,
  output logic      [7:0]             operand_o,
  output logic      [15:0]            next_pc_o,
  output logic      [15:0]            target_o,
  output logic                        vector_fetch_o
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  opgen_pkg::seq_state_e state_ff;
  opgen_pkg::addr_mode_e mode_ff;
  logic [7:0]            idx_ff;
  logic [15:0]           pc_ff;
  logic [15:0]           addr_ff;
  logic [15:0]           word_ff;
  logic [1:0]            left_ff;
  logic [1:0]            nbytes_ff;
  logic                  irq_pend_ff;
  logic [7:0]            tail_ff;
  logic [7:0]            lat_ff;

  logic                  accept;
  logic                  refuse;
  logic                  last_byte;
  logic [15:0]           word_nxt;
  logic [15:0]           nxt_pc;
  logic [15:0]           idx_sum;
  logic [15:0]           rel_sum;
  logic [15:0]           nxt_ea;

  // a pending interrupt holds off new instructions until its vector
  assign busy_o     = (state_ff != opgen_pkg::ST_IDLE) || irq_pend_ff;
  assign accept     = ce_i && start_i && !busy_o;
  assign refuse     = short_only_i && (opgen_pkg::is_long(mode_i) ||
                      (mode_i == opgen_pkg::MODE_IMM)); // RULE16
  assign mem_req_o  = (state_ff == opgen_pkg::ST_OPND) ||
                      (state_ff == opgen_pkg::ST_PTR);
  assign mem_addr_o = addr_ff;
  assign last_byte  = (left_ff == 2'h1);
  // earlier byte slides into the high half
  assign word_nxt   = {word_ff[7:0], mem_rdata_i}; // RULE18

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff  <= opgen_pkg::ST_IDLE;
      left_ff   <= 2'h0;
      nbytes_ff <= 2'h0;
    end else if (ce_i) begin
      case (state_ff)
        opgen_pkg::ST_IDLE: begin
          if (accept && !refuse) begin
            nbytes_ff <= 2'h0;
            if (opgen_pkg::opnd_bytes(mode_i) != 2'h0) begin
              state_ff <= opgen_pkg::ST_OPND;
              left_ff  <= opgen_pkg::opnd_bytes(mode_i);
            end else begin
              // no operand byte at all for these
              state_ff <= opgen_pkg::ST_FIN; // RULE5
            end
          end
        end
        opgen_pkg::ST_OPND: begin
          if (mem_ack_i) begin
            nbytes_ff <= nbytes_ff + 2'h1;
            left_ff   <= left_ff - 2'h1;
            if (last_byte) begin
              if (opgen_pkg::ptr_bytes(mode_ff) != 2'h0) begin
                state_ff <= opgen_pkg::ST_PTR; // RULE8
                left_ff  <= opgen_pkg::ptr_bytes(mode_ff); // RULE10
              end else begin
                state_ff <= opgen_pkg::ST_FIN;
              end
            end
          end
        end
        opgen_pkg::ST_PTR: begin
          if (mem_ack_i) begin
            left_ff <= left_ff - 2'h1;
            if (last_byte) begin
              state_ff <= opgen_pkg::ST_FIN;
            end
          end
        end
        opgen_pkg::ST_FIN: begin
          state_ff <= opgen_pkg::ST_IDLE;
        end
        default: begin
          state_ff <= opgen_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // captured instruction context
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_ff <= opgen_pkg::MODE_INH;
      idx_ff  <= opgen_pkg::RESET_BYTE;
      pc_ff   <= opgen_pkg::RESET_ADDR;
    end else if (accept && !refuse) begin
      mode_ff <= mode_i;
      idx_ff  <= use_y_i ? idx_y_i : idx_x_i; // RULE4
      pc_ff   <= pc_i;
    end
  end

  // ------------------------------------------------------------------
  // memory address and fetched bytes
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_ff <= opgen_pkg::RESET_ADDR;
      word_ff <= opgen_pkg::RESET_ADDR;
    end else if (ce_i) begin
      if (accept && !refuse) begin
        addr_ff <= pc_i + 16'h0001;
        word_ff <= opgen_pkg::RESET_ADDR;
      end else if (mem_req_o && mem_ack_i) begin
        if ((state_ff == opgen_pkg::ST_OPND) && last_byte &&
            (opgen_pkg::ptr_bytes(mode_ff) != 2'h0)) begin
          // pointer address is a page-zero byte
          addr_ff <= {8'h00, mem_rdata_i}; // RULE8
          word_ff <= opgen_pkg::RESET_ADDR; // RULE15
        end else begin
          addr_ff <= addr_ff + 16'h0001;
          word_ff <= word_nxt; // RULE3
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // address arithmetic
  // ------------------------------------------------------------------
  assign nxt_pc = pc_ff + 16'h0001 +
                  {14'h0000, opgen_pkg::opnd_bytes(mode_ff)}; // RULE1

  // zero-extended index; sum wraps in 16 bits
  offset_adder u_idx_add (
    .base_i (word_ff),
    .off_i  (idx_ff),
    .sext_i (1'b0),
    .sum_o  (idx_sum)
  ); // RULE19

  // branch base is the address after the whole instruction
  offset_adder u_rel_add (
    .base_i (nxt_pc),
    .off_i  (word_ff[7:0]),
    .sext_i (1'b1),
    .sum_o  (rel_sum)
  ); // RULE13

  always_comb begin
    case (mode_ff)
      opgen_pkg::MODE_DIR_S, opgen_pkg::MODE_IND_S:
        nxt_ea = {8'h00, word_ff[7:0]}; // RULE2 RULE9
      opgen_pkg::MODE_DIR_L, opgen_pkg::MODE_IND_L:
        nxt_ea = word_ff; // RULE3 RULE10
      opgen_pkg::MODE_IDX_N:
        nxt_ea = {8'h00, idx_ff}; // RULE5
      opgen_pkg::MODE_IDX_S, opgen_pkg::MODE_IDX_L:
        nxt_ea = idx_sum; // RULE6 RULE7
      opgen_pkg::MODE_IIX_S, opgen_pkg::MODE_IIX_L:
        nxt_ea = idx_sum; // RULE11 RULE12
      default:
        nxt_ea = opgen_pkg::RESET_ADDR;
    endcase
  end

  // ------------------------------------------------------------------
  // results, held until the next instruction finishes
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ea_o      <= opgen_pkg::RESET_ADDR;
      operand_o <= opgen_pkg::RESET_BYTE;
      next_pc_o <= opgen_pkg::RESET_ADDR;
      target_o  <= opgen_pkg::RESET_ADDR;
    end else if (ce_i && (state_ff == opgen_pkg::ST_FIN)) begin
      ea_o      <= nxt_ea;
      // immediate value or relative offset
      operand_o <= word_ff[7:0]; // RULE1 RULE14 RULE15
      next_pc_o <= nxt_pc;
      target_o  <= rel_sum; // RULE13
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done_o    <= 1'b0;
      illegal_o <= 1'b0;
    end else if (ce_i) begin
      done_o    <= (state_ff == opgen_pkg::ST_FIN);
      illegal_o <= accept && refuse; // RULE16
    end
  end

  // ------------------------------------------------------------------
  // interrupt reaction
  // ------------------------------------------------------------------
  // tail counts only once the current instruction has drained
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_pend_ff    <= 1'b0;
      tail_ff        <= 8'h00;
      vector_fetch_o <= 1'b0;
    end else if (ce_i) begin
      vector_fetch_o <= 1'b0;
      if (irq_i) begin
        // new event wins over the clear by a vector fetch
        irq_pend_ff <= 1'b1;
      end else if (vector_fetch_o) begin
        irq_pend_ff <= 1'b0;
      end
      if (irq_pend_ff && !vector_fetch_o &&
          (state_ff == opgen_pkg::ST_IDLE)) begin
        if (tail_ff == opgen_pkg::IRQ_TAIL_CYC - 8'h01) begin
          vector_fetch_o <= 1'b1; // RULE17
          tail_ff        <= 8'h00;
        end else begin
          tail_ff <= tail_ff + 8'h01;
        end
      end
    end
  end

  // latency from event, read only by checks
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lat_ff <= 8'h00;
    end else if (ce_i) begin
      if (!irq_pend_ff || vector_fetch_o) begin
        lat_ff <= 8'h00;
      end else if (lat_ff != 8'hff) begin
        lat_ff <= lat_ff + 8'h01;
      end
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_IMM_LEN: assert property ( // RULE1
    @(posedge clk_i) disable iff (!arst_n_i)
    done_o && (mode_ff == opgen_pkg::MODE_IMM) |->
      (next_pc_o == pc_ff + 16'h0002) && (nbytes_ff == 2'h1))
    else $error("immediate instruction length is not two bytes");

  AST_DIR_S_RANGE: assert property ( // RULE2
    @(posedge clk_i) disable iff (!arst_n_i)
    done_o && (mode_ff == opgen_pkg::MODE_DIR_S) |->
      ea_o <= opgen_pkg::SHORT_EA_MAX)
    else $error("short direct address out of page zero");

  AST_IDX_N: assert property ( // RULE5
    @(posedge clk_i) disable iff (!arst_n_i)
    done_o && (mode_ff == opgen_pkg::MODE_IDX_N) |->
      (ea_o == {8'h00, idx_ff}) && (next_pc_o == pc_ff + 16'h0001))
    else $error("no-offset indexed address is not the index");

  AST_IDX_S_RANGE: assert property ( // RULE6
    @(posedge clk_i) disable iff (!arst_n_i)
    done_o && (mode_ff == opgen_pkg::MODE_IDX_S) |->
      ea_o <= opgen_pkg::SHORT_IDX_EA_MAX)
    else $error("short indexed address beyond 1FE");

  AST_IIX_S_RANGE: assert property ( // RULE12
    @(posedge clk_i) disable iff (!arst_n_i)
    done_o && (mode_ff == opgen_pkg::MODE_IIX_S) |->
      (ea_o <= opgen_pkg::SHORT_IDX_EA_MAX) && (ea_o >= {8'h00, idx_ff}))
    else $error("short indirect indexed address out of range");

  AST_IND_L_BYTES: assert property ( // RULE10
    @(posedge clk_i) disable iff (!arst_n_i)
    ce_i && (state_ff == opgen_pkg::ST_OPND) && mem_ack_i &&
    (mode_ff == opgen_pkg::MODE_IND_L) |=>
      (state_ff == opgen_pkg::ST_PTR) && (left_ff == 2'h2) &&
      (mem_addr_o[15:8] == 8'h00))
    else $error("long indirect pointer fetch not set up");

  AST_REL_TARGET: assert property ( // RULE13
    @(posedge clk_i) disable iff (!arst_n_i)
    done_o && (mode_ff == opgen_pkg::MODE_REL_D) |->
      target_o == next_pc_o + {{8{operand_o[7]}}, operand_o})
    else $error("relative target is not pc plus signed offset");

  AST_REFUSE_LONG: assert property ( // RULE16
    @(posedge clk_i) disable iff (!arst_n_i)
    accept && refuse |=> illegal_o && (state_ff == opgen_pkg::ST_IDLE))
    else $error("long mode taken by a short-only instruction");

  AST_IRQ_TAIL: assert property ( // RULE17
    @(posedge clk_i) disable iff (!arst_n_i)
    vector_fetch_o |-> (lat_ff >= opgen_pkg::IRQ_MIN_CYC))
    else $error("vector fetched before the ten-cycle tail");

  // a moving address under a held request would read the wrong byte
  AST_REQ_HOLD: assert property ( // RULE8
    @(posedge clk_i) disable iff (!arst_n_i)
    mem_req_o && !(ce_i && mem_ack_i) |=>
      mem_req_o && $stable(mem_addr_o))
    else $error("memory request dropped or moved before ack");

  AST_PTR_PAGE0: assert property ( // RULE9
    @(posedge clk_i) disable iff (!arst_n_i)
    (state_ff == opgen_pkg::ST_PTR) &&
    (opgen_pkg::ptr_bytes(mode_ff) == 2'h1) |->
      mem_addr_o[15:8] == 8'h00)
    else $error("byte pointer read outside page zero");

endmodule // operand_address_generator

// [core/opgen_pkg.sv]
// shared constants, mode codes and helpers for the operand address generator
// assumes one 8-bit core clock domain and a byte-wide unified memory space
package opgen_pkg;

  // ------------------------------------------------------------------
  // widths and limits
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  localparam logic [15:0] RESET_ADDR       = 16'h0000;
  localparam logic [15:0] SHORT_EA_MAX     = 16'h00ff;
  localparam logic [15:0] SHORT_IDX_EA_MAX = 16'h01fe;
  localparam logic [7:0]  RESET_BYTE       = 8'h00;

  // interrupt reaction: finish instruction, then a fixed tail
  localparam logic [7:0]  IRQ_TAIL_CYC  = 8'h0a;
  localparam logic [7:0]  IRQ_MIN_CYC   = 8'h0a;
  localparam logic [7:0]  IRQ_MAX_CYC   = 8'h16;
  localparam logic [7:0]  INSTR_MAX_CYC = 8'h0c;

  // ------------------------------------------------------------------
  // addressing modes and sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_INH   = 4'h0,
    MODE_IMM   = 4'h1,
    MODE_DIR_S = 4'h2,
    MODE_DIR_L = 4'h3,
    MODE_IDX_N = 4'h4,
    MODE_IDX_S = 4'h5,
    MODE_IDX_L = 4'h6,
    MODE_IND_S = 4'h7,
    MODE_IND_L = 4'h8,
    MODE_IIX_S = 4'h9,
    MODE_IIX_L = 4'ha,
    MODE_REL_D = 4'hb,
    MODE_REL_I = 4'hc
  } addr_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_OPND = 4'h2,
    ST_PTR  = 4'h4,
    ST_FIN  = 4'h8
  } seq_state_e;

  // ------------------------------------------------------------------
  // per-mode byte counts
  // ------------------------------------------------------------------
  function automatic logic [1:0] opnd_bytes(input addr_mode_e m);
    case (m)
      MODE_INH, MODE_IDX_N:  opnd_bytes = 2'h0;
      MODE_DIR_L, MODE_IDX_L: opnd_bytes = 2'h2;
      default:               opnd_bytes = 2'h1;
    endcase
  endfunction

  function automatic logic [1:0] ptr_bytes(input addr_mode_e m);
    case (m)
      MODE_IND_S, MODE_IIX_S, MODE_REL_I: ptr_bytes = 2'h1;
      MODE_IND_L, MODE_IIX_L:             ptr_bytes = 2'h2;
      default:                            ptr_bytes = 2'h0;
    endcase
  endfunction

  function automatic logic is_long(input addr_mode_e m);
    is_long = (m == MODE_DIR_L) || (m == MODE_IDX_L) ||
              (m == MODE_IND_L) || (m == MODE_IIX_L);
  endfunction

endpackage

// [test/mem_model.sv]
// partner model: byte-wide memory space answering the operand fetches
// assumes requests are held until ack; content is a fixed address pattern
`timescale 1ns/1ps
module mem_model (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [1:0]  wait_i,
  input  wire logic        mem_req_i,
  input  wire logic [15:0] mem_addr_i,
  output logic             mem_ack_o,
  output logic      [7:0]  mem_rdata_o
);
  // ------------------------------------------------------------------
  // wait states and read data
  // ------------------------------------------------------------------
  logic [1:0] cnt_ff;
  logic [7:0] last_ff;

  assign mem_ack_o = mem_req_i && (cnt_ff == wait_i);
  // no stale data outside an ack: bus shows the inverse of the last byte
  assign mem_rdata_o = mem_ack_o ?
                       (mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'ha5) :
                       ~last_ff;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff  <= 2'h0;
      last_ff <= 8'h00;
    end else if (mem_ack_o) begin
      cnt_ff  <= 2'h0;
      last_ff <= mem_rdata_o;
    end else if (mem_req_i) begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end
endmodule // mem_model

// [test/operand_address_generator_tb_top.sv]
// testbench for the operand address generator with a memory model
// assumes inputs change at the falling edge of a 125 MHz clock
`timescale 1ns/1ps
module operand_address_generator_tb_top;
  // ------------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------------
  logic                 clk_i = 1'b0;
  logic                 arst_n_i = 1'b0;
  logic                 ce_i = 1'b1;
  logic                 start_i = 1'b0;
  opgen_pkg::addr_mode_e mode_i = opgen_pkg::MODE_INH;
  logic                 short_only_i = 1'b0;
  logic                 use_y_i = 1'b0;
  logic [7:0]           idx_x_i = 8'hff;
  logic [7:0]           idx_y_i = 8'h81;
  logic [15:0]          pc_i = 16'h0000;
  logic                 irq_i = 1'b0;
  logic [1:0]           wait_c = 2'h0;
  logic                 mem_ack_i, mem_req_o, busy_o, done_o, illegal_o;
  logic                 vector_fetch_o;
  logic [7:0]           mem_rdata_i, operand_o;
  logic [15:0]          mem_addr_o, ea_o, next_pc_o, target_o;
  int                   err_count = 0;
  int                   tests_run = 0;

  always #4 clk_i = ~clk_i;

  operand_address_generator operand_address_generator_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .start_i(start_i),
    .mode_i(mode_i), .short_only_i(short_only_i), .use_y_i(use_y_i),
    .idx_x_i(idx_x_i), .idx_y_i(idx_y_i), .pc_i(pc_i),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .irq_i(irq_i),
    .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .busy_o(busy_o),
    .done_o(done_o), .illegal_o(illegal_o), .ea_o(ea_o),
    .operand_o(operand_o), .next_pc_o(next_pc_o), .target_o(target_o),
    .vector_fetch_o(vector_fetch_o));

  mem_model mem_model_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .wait_i(wait_c),
    .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
    .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'ha5;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // edges until done or refusal; optional clock-enable freeze
  task automatic wait_result(input int fz, output int n);
    n = 0;
    while (n < 200) begin
      @(posedge clk_i);
      n++;
      @(negedge clk_i);
      start_i = 1'b0;
      if (fz > 0 && n == 1) ce_i = 1'b0;
      if (fz > 0 && n == 1 + fz) ce_i = 1'b1;
      if (done_o === 1'b1 || illegal_o === 1'b1) return;
    end
    err_count++;
    test_done();
  endtask

  task automatic launch(input opgen_pkg::addr_mode_e m, input logic so,
                        input logic uy, input logic [15:0] pc);
    mode_i = m;
    short_only_i = so;
    use_y_i = uy;
    pc_i = pc;
    start_i = 1'b1;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic run_mode(input opgen_pkg::addr_mode_e m, input logic uy,
                          input logic [15:0] pc, input int fz,
                          input logic so);
    logic [15:0] p, ea, npc;
    logic [7:0]  b1, idx, op;
    int          nb, n;
    b1 = mb(pc + 16'h0001);
    idx = uy ? idx_y_i : idx_x_i;
    p = {8'h00, b1};
    op = b1;
    ea = 16'h0000;
    nb = 1;
    npc = pc + 16'h0002;
    case (m)
      opgen_pkg::MODE_INH: begin nb = 0; npc = pc + 16'h0001; end
      opgen_pkg::MODE_DIR_S: ea = p;
      opgen_pkg::MODE_DIR_L: begin
        nb = 2; npc = pc + 16'h0003; ea = {b1, mb(pc + 16'h0002)};
      end
      opgen_pkg::MODE_IDX_N: begin
        nb = 0; npc = pc + 16'h0001; ea = {8'h00, idx};
      end
      opgen_pkg::MODE_IDX_S: ea = p + idx;
      opgen_pkg::MODE_IDX_L: begin
        nb = 2;
        npc = pc + 16'h0003;
        ea = {b1, mb(pc + 16'h0002)} + idx;
      end
      opgen_pkg::MODE_IND_S: begin nb = 2; ea = {8'h00, mb(p)}; end
      opgen_pkg::MODE_IND_L: begin
        nb = 3;
        ea = {mb(p), mb(p + 16'h0001)};
      end
      opgen_pkg::MODE_IIX_S: begin nb = 2; ea = mb(p) + idx; end
      opgen_pkg::MODE_IIX_L: begin
        nb = 3; ea = {mb(p), mb(p + 16'h0001)} + idx;
      end
      opgen_pkg::MODE_REL_I: begin nb = 2; op = mb(p); end
      default: ;
    endcase
    launch(m, so, uy, pc);
    wait_result(fz, n);
    check({15'h0000, done_o}, 16'h0001);
    check(16'(n), 16'(2 + nb * (1 + wait_c) + fz));
    check(ea_o, ea);
    check(next_pc_o, npc);
    if (m == opgen_pkg::MODE_IMM || m == opgen_pkg::MODE_REL_D ||
        m == opgen_pkg::MODE_REL_I) begin
      check({8'h00, operand_o}, {8'h00, op});
    end
    if (m == opgen_pkg::MODE_REL_D || m == opgen_pkg::MODE_REL_I) begin
      check(target_o, npc + {{8{op[7]}}, op});
    end
  endtask

  task automatic refuse(input opgen_pkg::addr_mode_e m);
    int n;
    launch(m, 1'b1, 1'b0, 16'h2340);
    wait_result(0, n);
    check({15'h0000, illegal_o}, 16'h0001);
    check(16'(n), 16'h0001);
    repeat (6) begin
      @(negedge clk_i);
      check({15'h0000, done_o}, 16'h0000);
    end
  endtask

  // irq from idle, then irq landing together with a long fetch
  task automatic irq_test(input logic with_instr);
    int n;
    irq_i = 1'b1;
    if (with_instr) launch(opgen_pkg::MODE_IND_L, 1'b0, 1'b0, 16'h0450);
    n = 0;
    while (vector_fetch_o !== 1'b1 && n < 60) begin
      @(posedge clk_i);
      n++;
      @(negedge clk_i);
      irq_i = 1'b0;
      start_i = (!with_instr && n == 3);
      if (!with_instr) check({15'h0000, done_o}, 16'h0000);
      if (!with_instr) check({15'h0000, mem_req_o}, 16'h0000);
      check({15'h0000, busy_o}, 16'h0001);
    end
    if (!with_instr) check(16'(n), 16'h000b);
    else check(16'(n), 16'(2 + 3 * (1 + wait_c) + 10));
    if (with_instr) check({15'h0000, (n >= 11 && n <= 23)}, 16'h0001);
    start_i = 1'b0;
    repeat (3) @(negedge clk_i);
    $display("irq test done, %0d cycles", n);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    arst_n_i = 1'b1;
    for (int w = 0; w < 3; w += 2) begin
      wait_c = 2'(w);
      for (int m = 0; m < 13; m++) begin
        run_mode(opgen_pkg::addr_mode_e'(m), m[0],
                 16'(16'h7fb0 + m * 16'h0111), 0, 1'b0);
      end
      $display("mode sweep done, wait %0d", w);
    end
    wait_c = 2'h0;
    run_mode(opgen_pkg::MODE_DIR_L, 1'b0, 16'h1200, 3, 1'b0);
    run_mode(opgen_pkg::MODE_DIR_S, 1'b0, 16'h1300, 0, 1'b1);
    $display("freeze and short class done");
    refuse(opgen_pkg::MODE_IMM);
    refuse(opgen_pkg::MODE_DIR_L);
    refuse(opgen_pkg::MODE_IDX_L);
    refuse(opgen_pkg::MODE_IND_L);
    refuse(opgen_pkg::MODE_IIX_L);
    $display("refusal test done");
    wait_c = 2'h2;
    irq_test(1'b0);
    irq_test(1'b1);
    test_done();
  end
endmodule // operand_address_generator_tb_top
